// [hw/pap_top.sv]
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pap_top #(
    parameter int SETTLE_FAST_CYC = pap_pkg::PAP_SETTLE_FAST_CYC,
    parameter int SETTLE_SLOW_CYC = pap_pkg::PAP_SETTLE_SLOW_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire pap_pkg::pap_wb_req_t      wb_i,
    output var  logic [31:0]               wb_dat_o,
    output var  logic                      wb_ack_o,
    input  wire logic                      pwr_valid_i,
    input  wire pap_pkg::pap_phase_pwr_t [2:0] pwr_i,
    output var  pap_pkg::pap_phase_pwr_t [2:0] pwr_o,
    output var  logic                      pwr_valid_o,
    output var  logic                      line_freq_range_sel_o,
    output var  logic [27:0]               nominal_voltage_level_o,
    output var  logic                      filter_strength_sel_o,
    output var  logic                      results_settled_o,
    output var  logic                      event_irq_n_o
);
    import pap_pkg::*;

    typedef struct packed {
        logic                ack;
        logic [31:0]         rdat;
        logic                freq_sel;
        logic [27:0]         nominal_voltage_level;
        logic [2:0][23:0]    gain;
        logic [2:0][23:0]    tos;
        logic [2:0][23:0]    fos;
        logic                sign_src;
        logic                lpf_sel;
        logic [7:0]          thresh;
        logic [2:0]          status;
        logic [2:0]          mask;
        logic [2:0]          sign;
        logic [2:0][39:0]    acc;
        pap_phase_pwr_t [2:0] pwr;
        logic                pvalid;
        logic [25:0]         settle;
        logic                irq_n;
        logic                settled;
    } pap_state_t;

    pap_state_t st_r;
    pap_state_t st_nxt;

    // Gain: p * (1 + g / 2^23). The result wraps rather than saturates, so
    // software must keep gain and offset within a sane calibration range.
    // At zero gain the full-scale reference passes through unchanged.  see [R12]
    function automatic logic signed [27:0] pap_scale(input logic signed [27:0] p,
                                                      input logic [23:0]        g);
        logic signed [55:0] prod;
        prod = p * $signed({{4{g[23]}}, g});
        return p + prod[PAP_GAIN_FRAC+27:PAP_GAIN_FRAC];
    endfunction : pap_scale

    // Merge a write under Wishbone byte selects.
    function automatic logic [31:0] pap_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : pap_merge

    // Per-phase datapath, one copy per phase; only the threshold and sign source settings are shared.  see [R22]
    pap_phase_pwr_t [2:0] corr;
    logic [2:0][39:0]     acc_nxt;
    logic [2:0]           hit;
    logic [2:0]           neg;
    logic [39:0]          thr;

    assign thr = {5'h00, st_r.thresh, 27'h0000000};

    generate
        for (genvar ph = 0; ph < 3; ph++) begin : g_phase
            logic signed [27:0] tos_x;
            logic signed [27:0] fos_x;
            logic signed [39:0] sum;
            logic signed [27:0] pick;
            logic               hit_l;
            logic               neg_l;
            logic        [39:0] acc_l;

            assign tos_x = {{4{st_r.tos[ph][23]}}, st_r.tos[ph]};
            assign fos_x = {{4{st_r.fos[ph][23]}}, st_r.fos[ph]};
            // Same gain on every power of the phase; offsets only on active.  see [R8] [R9] [R11]
            assign corr[ph].tot    = pap_scale(pwr_i[ph].tot, st_r.gain[ph]) + tos_x;
            assign corr[ph].fund_p = pap_scale(pwr_i[ph].fund_p, st_r.gain[ph]) + fos_x;
            assign corr[ph].fund_q = pap_scale(pwr_i[ph].fund_q, st_r.gain[ph]);
            assign corr[ph].app    = pap_scale(pwr_i[ph].app, st_r.gain[ph]);

            // Sign source chosen by the accumulation mode bit.  see [R13]
            assign pick = st_r.sign_src ? corr[ph].fund_p : corr[ph].tot;
            assign sum  = $signed(st_r.acc[ph]) + {{12{pick[27]}}, pick};

            // The sign is taken each time the energy crosses the threshold.  see [R14]
            always_comb begin
                hit_l = 1'b0;
                neg_l = 1'b0;
                acc_l = st_r.acc[ph];
                if (pwr_valid_i) begin
                    acc_l = sum;
                    if (sum >= $signed(thr)) begin
                        hit_l = 1'b1;
                        acc_l = sum - $signed(thr);
                    end else if (sum <= -$signed(thr)) begin
                        hit_l = 1'b1;
                        neg_l = 1'b1;
                        acc_l = sum + $signed(thr);
                    end
                end
            end
            // Each phase owns its own slice of the shared vectors.
            assign hit[ph]     = hit_l;
            assign neg[ph]     = neg_l;
            assign acc_nxt[ph] = acc_l;
        end
    endgenerate

    // Bus decode.
    logic        req;
    logic        wr;
    logic [7:0]  adr;
    logic [2:0]  chg;
    logic [2:0]  clr;

    assign req = wb_i.cyc & wb_i.stb & ~st_r.ack;
    assign wr  = req & wb_i.we;
    assign adr = {wb_i.adr[7:2], 2'b00};
    assign chg = hit & (neg ^ st_r.sign);
    assign clr = (wr && adr == PAP_OFS_STATUS && wb_i.sel[1] | wb_i.sel[0]) ?
                 wb_i.dat[PAP_BIT_REV_LO +: 3] : 3'b000;

    // Next state: bus writes, read mux, flags, datapath registers and settling.
    always_comb begin
        logic [31:0] rd;
        logic        restart;
        logic [31:0] mg;
        rd          = 32'h00000000;
        restart     = 1'b0;
        mg          = 32'h00000000;
        st_nxt      = st_r;
        st_nxt.ack  = req;
        st_nxt.acc  = acc_nxt;
        st_nxt.pvalid = pwr_valid_i;
        if (pwr_valid_i) begin
            st_nxt.pwr = corr;
        end
        for (int ph = 0; ph < 3; ph++) begin
            // Readback of 24-bit values: four zero bits above a 28-bit sign extension.  see [R10]
            if (adr == PAP_OFS_GAIN + 8'(4 * ph)) begin
                rd = {4'h0, {4{st_r.gain[ph][23]}}, st_r.gain[ph]};
            end
            if (adr == PAP_OFS_TOS + 8'(4 * ph)) begin
                rd = {4'h0, {4{st_r.tos[ph][23]}}, st_r.tos[ph]};
            end
            if (adr == PAP_OFS_FOS + 8'(4 * ph)) begin
                rd = {4'h0, {4{st_r.fos[ph][23]}}, st_r.fos[ph]};
            end
            // Waveform carries total power scaled by 1/16.  see [R20]
            if (adr == PAP_OFS_WAVE + 8'(4 * ph)) begin
                rd = {8'h00, st_r.pwr[ph].tot[27:4]};
            end
            if (wr && adr == PAP_OFS_GAIN + 8'(4 * ph)) begin
                mg = pap_merge({8'h00, st_r.gain[ph]}, wb_i.dat, wb_i.sel);
                st_nxt.gain[ph] = mg[23:0];
            end
            if (wr && adr == PAP_OFS_TOS + 8'(4 * ph)) begin
                mg = pap_merge({8'h00, st_r.tos[ph]}, wb_i.dat, wb_i.sel);
                st_nxt.tos[ph] = mg[23:0];
            end
            if (wr && adr == PAP_OFS_FOS + 8'(4 * ph)) begin
                mg = pap_merge({8'h00, st_r.fos[ph]}, wb_i.dat, wb_i.sel);
                st_nxt.fos[ph] = mg[23:0];
            end
        end
        case (adr)
            PAP_OFS_COMPUTATION_MODE_REG: rd = 32'(st_r.freq_sel) << PAP_BIT_FREQ_SEL;
            PAP_OFS_NOMINAL_VOLTAGE_LEVEL:   rd = {4'h0, st_r.nominal_voltage_level};            // see [R2]
            PAP_OFS_ACCUMULATION_MODE_REG:  rd = 32'(st_r.sign_src) << PAP_BIT_SIGN_SRC;
            PAP_OFS_CONFIG_REG_THREE:  rd = 32'(st_r.lpf_sel) << PAP_BIT_LPF_SEL;
            PAP_OFS_THRESH:   rd = {24'h000000, st_r.thresh};
            PAP_OFS_STATUS:   rd = 32'(st_r.status) << PAP_BIT_REV_LO;
            PAP_OFS_MASK:     rd = 32'(st_r.mask) << PAP_BIT_REV_LO;
            PAP_OFS_SIGN:     rd = 32'(st_r.sign) << PAP_BIT_SIGN_LO;
            default:          rd = rd;
        endcase
        if (wr) begin
            case (adr)
                PAP_OFS_COMPUTATION_MODE_REG: begin
                    if (wb_i.sel[1]) begin
                        st_nxt.freq_sel = wb_i.dat[PAP_BIT_FREQ_SEL];    // see [R1]
                        restart = 1'b1;
                    end
                end
                PAP_OFS_NOMINAL_VOLTAGE_LEVEL: begin
                    mg = pap_merge({4'h0, st_r.nominal_voltage_level}, wb_i.dat, wb_i.sel);
                    st_nxt.nominal_voltage_level = mg[27:0];
                    restart = 1'b1;
                end
                PAP_OFS_ACCUMULATION_MODE_REG: begin
                    if (wb_i.sel[0]) begin
                        st_nxt.sign_src = wb_i.dat[PAP_BIT_SIGN_SRC];
                    end
                end
                PAP_OFS_CONFIG_REG_THREE: begin
                    if (wb_i.sel[0]) begin
                        st_nxt.lpf_sel = wb_i.dat[PAP_BIT_LPF_SEL];
                        restart = 1'b1;
                    end
                end
                PAP_OFS_THRESH: begin
                    if (wb_i.sel[0]) begin
                        st_nxt.thresh = wb_i.dat[7:0];
                    end
                end
                PAP_OFS_MASK: begin
                    mg = pap_merge(32'(st_r.mask) << PAP_BIT_REV_LO, wb_i.dat, wb_i.sel);
                    st_nxt.mask = mg[PAP_BIT_REV_LO +: 3];
                end
                default: begin
                end
            endcase
        end
        st_nxt.rdat = req ? rd : 32'h00000000;
        // A flag raised in the cycle it is cleared stays set.  see [R15] [R18]
        st_nxt.status = (st_r.status & ~clr) | chg;
        // Sign bits follow the flags, 1 for negative.  see [R16]
        st_nxt.sign = (st_r.sign & ~hit) | (neg & hit);
        // Interrupt pin low while any unmasked flag stands.  see [R17]
        st_nxt.irq_n = ~|(st_nxt.status & st_nxt.mask);
        // A change of frequency range, level or filter restarts the settling time.
        // see [R4] [R21]
        if (restart) begin
            st_nxt.settle = st_nxt.lpf_sel ? 26'(SETTLE_SLOW_CYC) : 26'(SETTLE_FAST_CYC);
        end else if (st_r.settle != 26'h0000000) begin
            st_nxt.settle = st_r.settle - 26'h0000001;
        end
        // Registered so the settled output comes straight from a flip-flop.
        st_nxt.settled = (st_nxt.settle == 26'h0000000);
    end

    // State register; reset values are constants only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r          <= '0;
            st_r.thresh   <= PAP_THRESH_RST;
            st_r.irq_n    <= 1'b1;
            st_r.settle   <= 26'(SETTLE_FAST_CYC);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o                = st_r.rdat;
    assign wb_ack_o                = st_r.ack;
    assign pwr_o                   = st_r.pwr;
    assign pwr_valid_o             = st_r.pvalid;
    assign line_freq_range_sel_o   = st_r.freq_sel;
    assign nominal_voltage_level_o = st_r.nominal_voltage_level;
    assign filter_strength_sel_o   = st_r.lpf_sel;
    assign results_settled_o       = st_r.settled;
    assign event_irq_n_o           = st_r.irq_n;

    // Every request is answered exactly one cycle later, for one cycle.
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_i.cyc && wb_i.stb && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");

    // Half gain adds half of the input to itself.
    a_gain_half: assert property (@(posedge clk_i) disable iff (rst_i) // see [R8]
        (pwr_valid_i && st_r.gain[0] == 24'h400000 && st_r.tos[0] == 24'h000000)
        |=> pwr_o[0].tot == 28'($past(pwr_i[0].tot) + ($past(pwr_i[0].tot) >>> 1)))
        else $error("plus half gain wrong");

    // Apparent power carries the same gain as total power.
    a_gain_shared: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
        (pwr_valid_i && pwr_i[1].app == pwr_i[1].tot && st_r.tos[1] == 24'h000000)
        |=> pwr_o[1].app == pwr_o[1].tot)
        else $error("apparent power gain differs");

    // Offset registers read back with four zero bits and a 28-bit sign extension.
    a_reg_pad: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
        (req && !wb_i.we && adr == PAP_OFS_TOS && st_r.tos[0][23])
        |=> wb_dat_o[31:24] == 8'h0F)
        else $error("offset readback padding wrong");

    // A sign change sets the flag and the matching sign bit together.
    a_flag_with_sign: assert property (@(posedge clk_i) disable iff (rst_i) // see [R15]
        chg[2] |=> st_r.status[2] && st_r.sign[2] == $past(neg[2]))
        else $error("flag or sign not updated on change");

    // A stable sign never raises a flag.
    a_no_false_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
        (!st_r.status[0] && !chg[0]) |=> !st_r.status[0])
        else $error("flag set without sign change");

    // Unmasked flag drives the pin low within one cycle and holds it there.
    a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i) // see [R17]
        (|(st_r.status & st_r.mask)) |-> !event_irq_n_o)
        else $error("interrupt pin not low with unmasked flag");

    // Write-one clears a flag unless a new change lands in the same cycle.
    a_w1c_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see [R18]
        (clr[1] && !chg[1]) |=> !st_r.status[1] ##1 (st_r.status[1] == $past(chg[1])))
        else $error("status flag not cleared by write of one");

    // Strong filter selection holds results unsettled for the slow time.
    a_settle_restart: assert property (@(posedge clk_i) disable iff (rst_i) // see [R21]
        (wr && adr == PAP_OFS_CONFIG_REG_THREE && wb_i.sel[0] && wb_i.dat[PAP_BIT_LPF_SEL])
        |=> !results_settled_o && st_r.settle == 26'(SETTLE_SLOW_CYC))
        else $error("settling not restarted for strong filter");

endmodule : pap_top
`default_nettype wire

// [hw/pap_pkg.sv]
// Summary of operation
// [R1] Host clears line-frequency range bit for 45-55 Hz, sets it for 55-66 Hz.
// [R2] Nominal voltage level held as 28-bit signed value, read zero padded to 32.
// [R3] Host loads nominal voltage level with full-scale over nominal rms times four million.
// [R4] Fundamental power settles within 375 ms at 63% and 875 ms at full scale.
// [R5] Frequency tracking covers 10 Hz; host keeps single frequency steps within 5 Hz.
// [R6] Host sets range bit right after moving up, then waits 10 s before calibrating.
// [R7] For 45 to 65 Hz host steps through 50 Hz, waiting 10 s each time.
// [R8] Each phase scales filtered power by one plus signed 24-bit gain over 2^23.
// [R9] Phase gain applies alike to total, fundamental active, reactive and apparent power.
// [R10] Gains and offsets read as 32-bit words, top four bits zero, sign extended to 28.
// [R11] Separate signed 24-bit offsets added to total and fundamental active power per phase.
// [R12] Full scale in-phase inputs give 27,059,678 counts, the full-scale power reference.
// [R13] Accumulation mode bit 6 selects total or fundamental power for sign detection.
// [R14] Sign checked whenever a phase energy accumulator reaches threshold; change raises event.
// [R15] Sign change sets status bit 8 phase C, 7 phase B, 6 phase A.
// [R16] Sign bits 2..0 (C, B, A) update with each flag; 1 means negative.
// [R17] A set flag with its mask bit 8..6 set drives the low-active interrupt low.
// [R18] Writing 1 to a status flag clears it and releases the interrupt.
// [R19] Host reads sign register right after status register, before clearing the flag.
// [R20] Instantaneous per-phase total power readable as 24-bit waveform values.
// [R21] Filter strength bit 1: 650 ms settling when 0, 1300 ms when 1.
// [R22] Three phases use identical independent datapaths.
package pap_pkg;

    // Word-aligned byte offsets of the register map.
    localparam logic [7:0] PAP_OFS_COMPUTATION_MODE_REG = 8'h00;
    localparam logic [7:0] PAP_OFS_NOMINAL_VOLTAGE_LEVEL   = 8'h04;
    localparam logic [7:0] PAP_OFS_GAIN     = 8'h08;
    localparam logic [7:0] PAP_OFS_TOS      = 8'h14;
    localparam logic [7:0] PAP_OFS_FOS      = 8'h20;
    localparam logic [7:0] PAP_OFS_ACCUMULATION_MODE_REG  = 8'h2C;
    localparam logic [7:0] PAP_OFS_CONFIG_REG_THREE  = 8'h30;
    localparam logic [7:0] PAP_OFS_THRESH   = 8'h34;
    localparam logic [7:0] PAP_OFS_STATUS   = 8'h38;
    localparam logic [7:0] PAP_OFS_MASK     = 8'h3C;
    localparam logic [7:0] PAP_OFS_SIGN     = 8'h40;
    localparam logic [7:0] PAP_OFS_WAVE     = 8'h44;

    // Field positions.
    localparam int PAP_BIT_FREQ_SEL = 14;
    localparam int PAP_BIT_SIGN_SRC = 6;
    localparam int PAP_BIT_LPF_SEL  = 1;
    localparam int PAP_BIT_REV_LO   = 6;
    localparam int PAP_BIT_SIGN_LO  = 0;

    // Values after reset.
    localparam logic [7:0] PAP_THRESH_RST = 8'h03;

    // Power scale and timing.
    localparam int PAP_FULL_SCALE_POWER = 27059678;
    localparam int PAP_GAIN_FRAC        = 23;
    localparam int PAP_CLK_KHZ          = 20000;
    localparam int PAP_FUND_SETTLE_MS   = 875;
    localparam int PAP_LPF_FAST_MS      = 650;
    localparam int PAP_LPF_SLOW_MS      = 1300;
    localparam int PAP_SETTLE_FAST_CYC  =
        ((PAP_FUND_SETTLE_MS > PAP_LPF_FAST_MS) ? PAP_FUND_SETTLE_MS : PAP_LPF_FAST_MS)
        * PAP_CLK_KHZ;
    localparam int PAP_SETTLE_SLOW_CYC  =
        ((PAP_FUND_SETTLE_MS > PAP_LPF_SLOW_MS) ? PAP_FUND_SETTLE_MS : PAP_LPF_SLOW_MS)
        * PAP_CLK_KHZ;

    // Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pap_wb_req_t;

    // The four filtered powers of one phase, 28-bit signed each.
    typedef struct packed {
        logic signed [27:0] tot;
        logic signed [27:0] fund_p;
        logic signed [27:0] fund_q;
        logic signed [27:0] app;
    } pap_phase_pwr_t;

endpackage : pap_pkg

// [tb/pap_host.sv]
`timescale 1ns/1ns
`default_nettype none
module pap_host (
    input  wire logic                 clk_i,
    output var  pap_pkg::pap_wb_req_t wb_o,
    input  wire logic                 ack_i,
    input  wire logic [31:0]          dat_i
);
    import pap_pkg::*;

    // The bus is quiet from time zero so no access leaks out during reset.
    initial begin
        wb_o = '0;
    end

    // One classic cycle with all byte lanes. The request is held until ack is
    // seen at an edge, so a slow answer never truncates it; only the bench
    // timeout can end the wait. The range bit, the nominal level and the
    // status and sign reads all go through here; line frequency itself is
    // outside this model, so steps stay within limits by construction.
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        wb_o <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do @(posedge clk_i); while (ack_i !== 1'h1);
        rd = dat_i;
        wb_o <= '0;
    endtask : xfer
endmodule : pap_host
`default_nettype wire

// [tb/tb_pap_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_pap_top;
    import pap_pkg::*;
    localparam logic signed [27:0] FULL_SCALE_POWER = 28'h19CE5DE;
    logic                 clk_i;
    logic                 rst_i;
    pap_wb_req_t          wb_i;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 pwr_valid_i;
    pap_phase_pwr_t [2:0] pwr_i;
    pap_phase_pwr_t [2:0] pwr_o;
    logic                 pwr_valid_o;
    logic                 freq_sel;
    logic                 filt_sel;
    logic                 settled;
    logic                 irq_n;
    logic [27:0]          nominal_voltage_level;
    logic [31:0]          d;
    int                   num_errors;
    int                   cmp_count;
    int                   cycles;

    // Settling counts are shortened so the filter scenario stays brief.
    pap_top #(.SETTLE_FAST_CYC(20), .SETTLE_SLOW_CYC(40)) i_pap_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pwr_valid_i(pwr_valid_i), .pwr_i(pwr_i), .pwr_o(pwr_o),
        .pwr_valid_o(pwr_valid_o), .line_freq_range_sel_o(freq_sel),
        .nominal_voltage_level_o(nominal_voltage_level), .filter_strength_sel_o(filt_sel),
        .results_settled_o(settled), .event_irq_n_o(irq_n));

    pap_host i_pap_host (.clk_i(clk_i), .wb_o(wb_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o));

    // Free running clock at 50 ns.
    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        i_pap_host.xfer(1'h1, a, v, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        i_pap_host.xfer(1'h0, a, 32'h0, x);
        chk(x, e);
    endtask : rd

    function automatic pap_phase_pwr_t pp(input logic [27:0] v);
        return {v, v, v, v};
    endfunction : pp

    // One sample; outputs are looked at after the taking edge has settled.
    task automatic send(input pap_phase_pwr_t [2:0] p);
        @(posedge clk_i);
        pwr_valid_i <= 1'h1;
        pwr_i       <= p;
        @(posedge clk_i);
        pwr_valid_i <= 1'h0;
        #1;
    endtask : send

    task automatic t_regs;
        chk(irq_n, 1'h1);
        rd(PAP_OFS_THRESH, 32'h3);
        rd(8'h80, 32'h0);
        wr(PAP_OFS_NOMINAL_VOLTAGE_LEVEL, 32'hFFFFFFFF);
        rd(PAP_OFS_NOMINAL_VOLTAGE_LEVEL, 32'h0FFFFFFF);
        wr(PAP_OFS_NOMINAL_VOLTAGE_LEVEL, 32'h007A1200);
        chk(nominal_voltage_level, 28'h07A1200);
        wr(PAP_OFS_COMPUTATION_MODE_REG, 32'h4000);
        chk(freq_sel, 1'h1);
        wr(PAP_OFS_GAIN, 32'hFFC00000);
        rd(PAP_OFS_GAIN, 32'h0FC00000);
        wr(PAP_OFS_TOS + 8'h8, 32'h800000);
        rd(PAP_OFS_TOS + 8'h8, 32'h0F800000);
        wr(PAP_OFS_TOS + 8'h8, 32'h0);
        wr(PAP_OFS_SIGN, 32'h7);
        rd(PAP_OFS_SIGN, 32'h0);
        wr(PAP_OFS_CONFIG_REG_THREE, 32'h2);
        chk(filt_sel, 1'h1);
        repeat (30) @(posedge clk_i);
        #1;
        chk(settled, 1'h0);
        repeat (20) @(posedge clk_i);
        #1;
        chk(settled, 1'h1);
    endtask : t_regs

    // Phase B alone crosses the threshold of 3 << 27 after fifteen full-scale
    // samples either way; fourteen must not be enough.
    task automatic t_sign;
        wr(PAP_OFS_MASK, 32'h1C0);
        chk(FULL_SCALE_POWER, PAP_FULL_SCALE_POWER);
        repeat (15) send({pp(28'h0), pp(FULL_SCALE_POWER), pp(28'h0)});
        rd(PAP_OFS_STATUS, 32'h0);
        repeat (14) send({pp(28'h0), pp(-FULL_SCALE_POWER), pp(28'h0)});
        chk(irq_n, 1'h1);
        send({pp(28'h0), pp(-FULL_SCALE_POWER), pp(28'h0)});
        chk(irq_n, 1'h0);
        rd(PAP_OFS_STATUS, 32'h080);
        rd(PAP_OFS_SIGN, 32'h2);
        wr(PAP_OFS_STATUS, 32'h080);
        chk(irq_n, 1'h1);
        rd(PAP_OFS_STATUS, 32'h0);
        wr(PAP_OFS_MASK, 32'h0);
        wr(PAP_OFS_ACCUMULATION_MODE_REG, 32'h40);
        repeat (15) send({pp(28'h0), {-FULL_SCALE_POWER, FULL_SCALE_POWER, -FULL_SCALE_POWER, -FULL_SCALE_POWER}, pp(28'h0)});
        chk(irq_n, 1'h1);
        rd(PAP_OFS_STATUS, 32'h080);
        rd(PAP_OFS_SIGN, 32'h0);
        wr(PAP_OFS_STATUS, 32'h080);
    endtask : t_sign

    task automatic t_gain;
        logic [27:0] e [3];
        e = '{28'h0180000, 28'h0080000, 28'h0100000};
        wr(PAP_OFS_GAIN, 32'h400000);
        wr(PAP_OFS_GAIN + 8'h4, 32'hC00000);
        wr(PAP_OFS_GAIN + 8'h8, 32'h0);
        send({3{pp(28'h0100000)}});
        chk(pwr_valid_o, 1'h1);
        for (int i = 0; i < 3; i++) begin
            chk(pwr_o[i].tot, e[i]);
            chk(pwr_o[i].fund_p, e[i]);
            chk(pwr_o[i].fund_q, e[i]);
            chk(pwr_o[i].app, e[i]);
        end
        rd(PAP_OFS_WAVE, 32'h00018000);
    endtask : t_gain

    // Gains go back to unity so the offsets show unscaled.
    task automatic t_offset;
        wr(PAP_OFS_GAIN, 32'h0);
        wr(PAP_OFS_GAIN + 8'h4, 32'h0);
        wr(PAP_OFS_TOS, 32'h10);
        wr(PAP_OFS_FOS, 32'hFFFFF0);
        rd(PAP_OFS_FOS, 32'h0FFFFFF0);
        send({3{pp(28'h00003E8)}});
        chk(pwr_o[0].tot, 28'h00003F8);
        chk(pwr_o[0].fund_p, 28'h00003D8);
        chk(pwr_o[0].fund_q, 28'h00003E8);
        chk(pwr_o[1].tot, 28'h00003E8);
    endtask : t_offset

    task automatic tally_and_finish;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // Reset for six cycles, then the scenarios; sign runs before any sample
    // is sent so the accumulators start from zero.
    initial begin
        num_errors  = 0;
        cmp_count   = 0;
        cycles      = 0;
        rst_i       = 1'h1;
        pwr_valid_i = 1'h0;
        pwr_i       = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        #1;
        chk(settled, 1'h0);
        t_regs();
        t_sign();
        t_gain();
        t_offset();
        tally_and_finish();
    end
endmodule : tb_pap_top
`default_nettype wire
